// ### timer_defs.svh
// Offsets, field positions, reset values and encodings of the event capture timer.
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL_A 5'h00
`define OFS_CONTROL_B 5'h04
`define OFS_EVENT_CONTROL 5'h08
`define OFS_STATUS 5'h0C
`define OFS_FLAGS 5'h10
`define OFS_COUNTER 5'h14
`define OFS_COMPARE 5'h18

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_ENABLE 0
`define CLOCK_SELECT_LSB 1
`define CLOCK_SELECT_MSB 2
`define MODE_LSB 0
`define MODE_MSB 2
`define BIT_COMPARE_OUTPUT 4
`define BIT_EDGE 4
`define BIT_RUN 0
`define BIT_CAPTURE 0

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define COUNT_BOTTOM 16'h0000
`define COUNT_MAX 16'hFFFF
`define COMPARE_RESET 16'h0000
`define CLOCK_SELECT_DIV1 2'h0
`define CLOCK_SELECT_DIV2 2'h1
`define CLOCK_SELECT_COMPANION 2'h2
`define CLOCK_SELECT_EVENT 2'h3

`endif

// ### timer_pkg.sv
// Types shared by the event capture timer files.
package timer_pkg;

   typedef enum logic [2:0] {
      MODE_PERIODIC = 3'h0,
      MODE_TIMEOUT = 3'h1,
      MODE_CAPTURE_EVENT = 3'h2,
      MODE_FREQUENCY = 3'h3,
      MODE_PULSE_WIDTH = 3'h4,
      MODE_FREQ_PULSE = 3'h5,
      MODE_SINGLE_SHOT = 3'h6,
      MODE_PWM8 = 3'h7
   } counter_mode_type;

   // Gray coded along wait -> run -> frozen.
   typedef enum logic [1:0] {
      TO_WAIT = 2'h0,
      TO_RUN = 2'h1,
      TO_FROZEN = 2'h3
   } timeout_state_type;

   typedef struct packed {
      logic read;
      logic write;
      logic [4:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } avalon_req_type;

   typedef struct packed {
      logic waitrequest;
      logic [31:0] readdata;
   } avalon_rsp_type;

endpackage

// ### tick_source.sv
// Counting clock enable: prescaled peripheral clock, companion timer tick or event tick.
`timescale 1ns/100ps
`include "timer_defs.svh"
module tick_source (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Selection
   input wire logic run_enable,
   input wire logic [1:0] clock_source_select,
   // Tick sources
   input wire logic companion_timer_clock,
   input wire logic event_tick,
   // Result
   output logic counting_clock
);

   logic half_rate;

   // ----------------------------------------------------------------
   // Divide by two
   // ----------------------------------------------------------------
   // The divider is held cleared while stopped so the first tick after
   // enable always lands at the same phase.
   always_ff @(posedge ref_clk) begin
      if (!rst_b || !run_enable) begin
         half_rate <= 1'b0;
      end else begin
         half_rate <= ~half_rate;
      end
   end

   always_comb begin
      case (clock_source_select)
         `CLOCK_SELECT_DIV1: counting_clock = run_enable;
         `CLOCK_SELECT_DIV2: counting_clock = run_enable & half_rate;
         `CLOCK_SELECT_COMPANION: counting_clock = run_enable & companion_timer_clock;
         default: counting_clock = run_enable & event_tick;
      endcase
   end

endmodule

// ### event_capture_timer_core.sv
// 16-bit event capture timer core with periodic interrupt and time-out check modes.
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "timer_defs.svh"
module event_capture_timer_core (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Register bus
   input wire timer_pkg::avalon_req_type bus_req,
   output timer_pkg::avalon_rsp_type bus_rsp,
   // Clock and event inputs
   input wire logic companion_timer_clock,
   input wire logic event_input,
   input wire logic event_tick,
   // Port pin
   input wire logic port_out_value,
   output logic pin_out,
   // Event output
   output logic capture_event
);
   import timer_pkg::*;

   logic [7:0] control_register_a;
   logic [7:0] control_register_b;
   logic [7:0] event_control_register;
   logic [15:0] counter_value;
   logic [15:0] compare_capture_value;
   logic capture_flag;
   logic waveform_output;
   logic bus_ack;
   logic [31:0] readdata;
   logic event_prev;
   timeout_state_type timeout_state;
   logic enable;
   logic [1:0] clock_source_select;
   counter_mode_type counter_mode_select;
   logic compare_output_enable;
   logic edge_invert;
   logic counting_clock;
   logic counting;
   logic run_status;
   logic rise;
   logic fall;
   logic start_edge;
   logic stop_edge;
   logic match;
   logic fire;
   logic bus_write;
   logic bus_read;

   // ----------------------------------------------------------------
   // Field decode
   // ----------------------------------------------------------------
   // All eight modes decode, but only periodic and time-out raise the flag;
   // the others free-run from BOTTOM to MAX until their logic is added.
   assign enable = control_register_a[`BIT_ENABLE];
   assign clock_source_select = control_register_a[`CLOCK_SELECT_MSB:`CLOCK_SELECT_LSB];
   assign counter_mode_select = counter_mode_type'(control_register_b[`MODE_MSB:`MODE_LSB]);
   assign compare_output_enable = control_register_b[`BIT_COMPARE_OUTPUT];
   assign edge_invert = event_control_register[`BIT_EDGE];

   // ----------------------------------------------------------------
   // Avalon-MM slave, one wait state
   // ----------------------------------------------------------------
   // Every access answers on its second edge; unmapped reads give zero
   // and unmapped writes are dropped.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         bus_ack <= 1'b0;
      end else begin
         bus_ack <= (bus_req.read | bus_req.write) & ~bus_ack;
      end
   end

   assign bus_rsp.waitrequest = (bus_req.read | bus_req.write) & ~bus_ack;
   assign bus_rsp.readdata = readdata;
   assign bus_write = bus_req.write & bus_ack;
   assign bus_read = bus_req.read & bus_ack;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         readdata <= 32'h00000000;
      end else if (bus_req.read && !bus_ack) begin
         case (bus_req.address)
            `OFS_CONTROL_A: readdata <= {24'h000000, control_register_a};
            `OFS_CONTROL_B: readdata <= {24'h000000, control_register_b};
            `OFS_EVENT_CONTROL: readdata <= {24'h000000, event_control_register};
            `OFS_STATUS: readdata <= {31'h00000000, run_status};
            `OFS_FLAGS: readdata <= {31'h00000000, capture_flag};
            `OFS_COUNTER: readdata <= {16'h0000, counter_value};
            `OFS_COMPARE: readdata <= {16'h0000, compare_capture_value};
            default: readdata <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         control_register_a <= 8'h00;
         control_register_b <= 8'h00;
         event_control_register <= 8'h00;
      end else if (bus_write && bus_req.byteenable[0]) begin
         case (bus_req.address)
            `OFS_CONTROL_A: control_register_a <= bus_req.writedata[7:0];
            `OFS_CONTROL_B: control_register_b <= bus_req.writedata[7:0];
            `OFS_EVENT_CONTROL: event_control_register <= bus_req.writedata[7:0];
            default: control_register_a <= control_register_a;
         endcase
      end
   end

   // Status writes are not stored anywhere, so a run bit write in the
   // frozen state leaves the timer untouched.

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         compare_capture_value <= `COMPARE_RESET;
      end else if (bus_write && bus_req.address == `OFS_COMPARE) begin
         if (bus_req.byteenable[0]) begin
            compare_capture_value[7:0] <= bus_req.writedata[7:0];
         end
         if (bus_req.byteenable[1]) begin
            compare_capture_value[15:8] <= bus_req.writedata[15:8];
         end
      end
   end

   // ----------------------------------------------------------------
   // Counting clock
   // ----------------------------------------------------------------
   tick_source u_tick_source (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .run_enable(enable),
      .clock_source_select(clock_source_select),
      .companion_timer_clock(companion_timer_clock),
      .event_tick(event_tick),
      .counting_clock(counting_clock)
   );

   // ----------------------------------------------------------------
   // Event edge detection
   // ----------------------------------------------------------------
   // The source keeps each level for more than a cycle, so one sample
   // of history is enough to see every edge.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         event_prev <= 1'b0;
      end else begin
         event_prev <= event_input;
      end
   end

   assign rise = event_input & ~event_prev;
   assign fall = ~event_input & event_prev;
   assign start_edge = edge_invert ? fall : rise;
   assign stop_edge = edge_invert ? rise : fall;

   // ----------------------------------------------------------------
   // Time-out check sequence
   // ----------------------------------------------------------------
   // Disabling the timer or leaving time-out mode drops the sequence back
   // to waiting, so a freeze left over from an earlier setup never holds
   // the counter once the mode is entered again.
   always_ff @(posedge ref_clk) begin
      if (!rst_b || !enable || counter_mode_select != MODE_TIMEOUT) begin
         timeout_state <= TO_WAIT;
      end else begin
         case (timeout_state)
            TO_WAIT: begin
               if (start_edge) begin
                  timeout_state <= TO_RUN;
               end
            end
            TO_RUN: begin
               if (stop_edge) begin
                  timeout_state <= TO_FROZEN;
               end
            end
            TO_FROZEN: begin
               if (start_edge) begin
                  timeout_state <= TO_RUN;
               end
            end
            default: timeout_state <= TO_WAIT;
         endcase
      end
   end

   assign counting = (counter_mode_select == MODE_TIMEOUT) ? (timeout_state == TO_RUN) : 1'b1;
   assign run_status = enable & counting;
   // The match is only acted on with a tick, so a slow counting clock
   // gives one event per period rather than one per system cycle.
   assign match = counter_value == compare_capture_value;
   assign fire = counting_clock & counting & match &
                 (counter_mode_select == MODE_PERIODIC || counter_mode_select == MODE_TIMEOUT);

   // ----------------------------------------------------------------
   // Base counter
   // ----------------------------------------------------------------
   // A bus write wins over counting; the plain increment carries the
   // count past a compare value left behind it up to MAX and back to BOTTOM.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         counter_value <= `COUNT_BOTTOM;
      end else if (bus_write && bus_req.address == `OFS_COUNTER) begin
         if (bus_req.byteenable[0]) begin
            counter_value[7:0] <= bus_req.writedata[7:0];
         end
         if (bus_req.byteenable[1]) begin
            counter_value[15:8] <= bus_req.writedata[15:8];
         end
      end else if (enable && counter_mode_select == MODE_TIMEOUT && timeout_state != TO_RUN && start_edge) begin
         counter_value <= `COUNT_BOTTOM;
      end else if (counting_clock && counting) begin
         if (counter_mode_select == MODE_PERIODIC && match) begin
            counter_value <= `COUNT_BOTTOM;
         end else if (counter_value == `COUNT_MAX) begin
            counter_value <= `COUNT_BOTTOM;
         end else begin
            counter_value <= counter_value + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Capture flag and outgoing event
   // ----------------------------------------------------------------
   // A new match in the same cycle as a clear keeps the flag set.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         capture_flag <= 1'b0;
      end else if (fire) begin
         capture_flag <= 1'b1;
      end else if (bus_read && bus_req.address == `OFS_COMPARE && bus_req.byteenable[0]) begin
         capture_flag <= 1'b0;
      end else if (bus_write && bus_req.address == `OFS_FLAGS && bus_req.byteenable[0] &&
                   bus_req.writedata[`BIT_CAPTURE]) begin
         capture_flag <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         capture_event <= 1'b0;
      end else begin
         capture_event <= fire;
      end
   end

   // ----------------------------------------------------------------
   // Waveform output
   // ----------------------------------------------------------------
   // The waveform toggles on each periodic or time-out mode event (fire) so its period is visible on the pin.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         waveform_output <= 1'b0;
      end else if (fire) begin
         waveform_output <= ~waveform_output;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         pin_out <= 1'b0;
      end else begin
         pin_out <= compare_output_enable ? waveform_output : port_out_value;
      end
   end

   // ----------------------------------------------------------------
   // Side effects of register access
   // ----------------------------------------------------------------
   // Reads load readdata and at most clear the flag, and status writes are dropped, so in the
   // frozen state neither a counter or compare read nor a run bit write
   // moves the counter or the sequence. Of the reads, only the compare low byte read
   // clears the capture flag, as it does in every mode.

endmodule

// ### event_capture_timer_core_sva.sv
// Port checks of the event capture timer core.
`timescale 1ns/100ps
`include "timer_defs.svh"
module event_capture_timer_core_sva import timer_pkg::*; (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Register bus
   input wire timer_pkg::avalon_req_type bus_req,
   input wire timer_pkg::avalon_rsp_type bus_rsp,
   // Ticks, events and pin
   input wire logic companion_timer_clock,
   input wire logic event_input,
   input wire logic event_tick,
   input wire logic port_out_value,
   input wire logic pin_out,
   input wire logic capture_event
);
   logic req;
   logic en;
   logic oe;
   logic [2:0] mode;
   assign req = bus_req.read | bus_req.write;
   // Shadow of the written settings, since the checker sees no internal register.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         en <= 1'b0;
         oe <= 1'b0;
         mode <= 3'h0;
      end else if (bus_req.write && !bus_rsp.waitrequest && bus_req.byteenable[0]) begin
         if (bus_req.address == `OFS_CONTROL_A)
            en <= bus_req.writedata[`BIT_ENABLE];
         if (bus_req.address == `OFS_CONTROL_B) begin
            oe <= bus_req.writedata[`BIT_COMPARE_OUTPUT];
            mode <= bus_req.writedata[2:0];
         end
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence s_wait; req && bus_rsp.waitrequest; endsequence
   sequence s_answer; req && !bus_rsp.waitrequest; endsequence
   property p_one_wait; s_wait |=> s_answer; endproperty
   a_one_wait: assert property (p_one_wait) else $error("answer not after one wait state");
   property p_new_wait; s_answer |=> !req || bus_rsp.waitrequest; endproperty
   a_new_wait: assert property (p_new_wait) else $error("next request got no wait state");
   property p_idle; !req |-> !bus_rsp.waitrequest; endproperty
   a_idle: assert property (p_idle) else $error("waitrequest without request");
   property p_reset_out; $rose(rst_b) |-> !capture_event && !pin_out && bus_rsp.readdata == 32'h0; endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not cleared by reset");
   property p_rdata; $changed(bus_rsp.readdata) |-> bus_req.read || $past(bus_req.read); endproperty
   a_rdata: assert property (p_rdata) else $error("read data changed without a read");
   property p_port; !oe && !$past(oe) && $past(rst_b) |-> pin_out == $past(port_out_value); endproperty
   a_port: assert property (p_port) else $error("pin does not follow port value");
   property p_stopped; !en && !$past(en) |-> !capture_event; endproperty
   a_stopped: assert property (p_stopped) else $error("event while disabled");
   property p_free_mode; mode > 3'h1 && $past(mode) > 3'h1 |-> !capture_event; endproperty
   a_free_mode: assert property (p_free_mode) else $error("event in a free running mode");
endmodule
bind event_capture_timer_core event_capture_timer_core_sva event_capture_timer_core_sva_i (
   .ref_clk(ref_clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rsp(bus_rsp),
   .companion_timer_clock(companion_timer_clock), .event_input(event_input), .event_tick(event_tick),
   .port_out_value(port_out_value), .pin_out(pin_out), .capture_event(capture_event));

// ### event_network_model.sv
// Model of the event routing network and the companion timer tick.
`timescale 1ns/100ps
module event_network_model #(
   parameter int COMPANION_DIV = 3,
   parameter int EVENT_DIV = 2
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // Requested event level
   input wire logic event_level,
   // Outputs to the timer
   output logic companion_timer_clock,
   output logic event_tick,
   output logic event_input
);
   int cc;
   int ec;
   int hold;
   always_ff @(posedge ref_clk) begin
      cc <= (!rst_b || cc == COMPANION_DIV - 1) ? 0 : cc + 1;
      companion_timer_clock <= rst_b && cc == COMPANION_DIV - 1;
   end
   always_ff @(posedge ref_clk) begin
      ec <= (!rst_b || ec == EVENT_DIV - 1) ? 0 : ec + 1;
      event_tick <= rst_b && ec == EVENT_DIV - 1;
   end
   // A new level passes only once the last one has stood two cycles.
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         event_input <= 1'b0;
         hold <= 0;
      end else if (event_level != event_input && hold >= 1) begin
         event_input <= event_level;
         hold <= 0;
      end else if (hold < 2)
         hold <= hold + 1;
   end
endmodule

// ### test_event_capture_timer_core.sv
// Self-checking bench of the event capture timer core.
`timescale 1ns/100ps
`include "timer_defs.svh"
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin mismatches++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module test_event_capture_timer_core;
   import timer_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   avalon_req_type bus_req = '0;
   avalon_rsp_type bus_rsp;
   logic event_level = 1'b0;
   logic port_out_value = 1'b0;
   logic companion_timer_clock, event_tick, event_input, pin_out, capture_event;
   int mismatches = 0;
   int tests_run = 0;
   int per [4] = '{1, 2, 3, 2};
   logic [31:0] q, c;
   logic p;
   int n;
   event_capture_timer_core event_capture_timer_core_i (.ref_clk(ref_clk), .rst_b(rst_b),
      .bus_req(bus_req), .bus_rsp(bus_rsp), .companion_timer_clock(companion_timer_clock),
      .event_input(event_input), .event_tick(event_tick), .port_out_value(port_out_value),
      .pin_out(pin_out), .capture_event(capture_event));
   event_network_model event_network_model_i (.ref_clk(ref_clk), .rst_b(rst_b),
      .event_level(event_level), .companion_timer_clock(companion_timer_clock),
      .event_tick(event_tick), .event_input(event_input));
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic test_done();
      $display("checks %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // One bus cycle; request held until waitrequest is sampled low.
   task automatic acc(input logic w, input logic [4:0] a, input logic [3:0] be, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge ref_clk);
      bus_req <= '{read: !w, write: w, address: a, byteenable: be, writedata: d};
      do begin
         @(posedge ref_clk);
         k++;
      end while (bus_rsp.waitrequest !== 1'b0 && k < 50);
      q = bus_rsp.readdata;
      bus_req <= '0;
      if (k >= 50)
         mismatches++;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      acc(1'b1, a, 4'hF, d);
   endtask
   task automatic rd(input logic [4:0] a);
      acc(1'b0, a, 4'hF, 32'h0);
   endtask
   task automatic wev();
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (capture_event !== 1'b1 && n < 3000);
      if (n >= 3000)
         mismatches++;
   endtask
   initial begin
      #(40 * 20000);
      mismatches++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      for (int a = 0; a < 32; a += 4) begin
         rd(5'(a));
         `CHK("reset value", 32'h0, q)
      end
      wr(5'h1C, 32'hFFFFFFFF);
      rd(5'h1C);
      `CHK("unmapped", 32'h0, q)
      wr(`OFS_COMPARE, 32'h5);
      for (int s = 0; s < 4; s++) begin
         wr(`OFS_CONTROL_A, 32'h0);
         wr(`OFS_COUNTER, 32'h0);
         wr(`OFS_CONTROL_A, 32'(s * 2 + 1));
         wev();
         wev();
         `CHK("event spacing", per[s] * 6, n)
      end
      rd(`OFS_STATUS);
      `CHK("running", 32'h1, q)
      wr(`OFS_CONTROL_A, 32'h0);
      rd(`OFS_FLAGS);
      `CHK("match flag", 32'h1, q)
      acc(1'b0, `OFS_COMPARE, 4'h2, 32'h0);
      rd(`OFS_FLAGS);
      `CHK("flag kept", 32'h1, q)
      rd(`OFS_COMPARE);
      rd(`OFS_FLAGS);
      `CHK("flag cleared", 32'h0, q)
      wr(`OFS_COUNTER, 32'hFFF0);
      wr(`OFS_CONTROL_A, 32'h1);
      wev();
      `CHK("wrap", 1'b1, n > 19 && n < 26)
      wr(`OFS_CONTROL_A, 32'h0);
      port_out_value <= 1'b1;
      repeat (3) @(posedge ref_clk);
      `CHK("pin", 1'b1, pin_out)
      wr(`OFS_CONTROL_B, 32'h10);
      wr(`OFS_CONTROL_A, 32'h1);
      wev();
      p = pin_out;
      wev();
      `CHK("waveform", ~p, pin_out)
      for (int m = 2; m < 8; m++) begin
         wr(`OFS_CONTROL_B, 32'(m));
         repeat (10) @(posedge ref_clk);
      end
      wr(`OFS_CONTROL_A, 32'h0);
      wr(`OFS_CONTROL_B, 32'h1);
      wr(`OFS_COUNTER, 32'h0);
      wr(`OFS_COMPARE, 32'h20);
      wr(`OFS_FLAGS, 32'h1);
      wr(`OFS_CONTROL_A, 32'h1);
      rd(`OFS_STATUS);
      `CHK("wait start", 32'h0, q)
      event_level <= 1'b1;
      repeat (4) @(posedge ref_clk);
      event_level <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rd(`OFS_COUNTER);
      c = q;
      rd(`OFS_COMPARE);
      wr(`OFS_STATUS, 32'h1);
      rd(`OFS_STATUS);
      `CHK("frozen run", 32'h0, q)
      rd(`OFS_COUNTER);
      `CHK("frozen count", c, q)
      `CHK("counted", 1'b1, c > 32'h3)
      rd(`OFS_FLAGS);
      `CHK("no flag", 32'h0, q)
      event_level <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(`OFS_COUNTER);
      `CHK("restart", 1'b1, q < c)
      wev();
      `CHK("time-out", 1'b1, n > 20 && n < 40)
      rd(`OFS_FLAGS);
      `CHK("time-out flag", 32'h1, q)
      wr(`OFS_CONTROL_A, 32'h0);
      wr(`OFS_EVENT_CONTROL, 32'h10);
      wr(`OFS_CONTROL_A, 32'h1);
      event_level <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rd(`OFS_STATUS);
      `CHK("fall starts", 32'h1, q)
      event_level <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(`OFS_STATUS);
      `CHK("rise stops", 32'h0, q)
      test_done();
   end
endmodule
